// ---- rtl/sagc_regs.svh ----
`ifndef SAGC_REGS_SVH
`define SAGC_REGS_SVH
// register indices on the two-wire control bus
`define SAGC_OFS_ANTICLIP 8'h62
`define SAGC_OFS_PWRLIM 8'h63
`define SAGC_OFS_RAMPFLR 8'h64
// implemented bits of each register
`define SAGC_MASK_ANTICLIP 16'h8f77
`define SAGC_MASK_PWRLIM 16'h9f77
`define SAGC_MASK_RAMPFLR 16'h013f
// reset values
`define SAGC_RST_ANTICLIP 16'h8640
`define SAGC_RST_PWRLIM 16'h8000
`define SAGC_RST_RAMPFLR 16'h0000
// field positions
`define SAGC_BIT_ENABLE 15
`define SAGC_BIT_MEASURE 12
`define SAGC_THR_MSB 11
`define SAGC_THR_LSB 8
`define SAGC_ATK_MSB 6
`define SAGC_ATK_LSB 4
`define SAGC_DCY_MSB 2
`define SAGC_DCY_LSB 0
`define SAGC_BIT_RAMP 8
`define SAGC_FLR_MSB 5
`define SAGC_FLR_LSB 0
// threshold and floor scaling
`define SAGC_THR_BASE_MW 11'h12c
`define SAGC_THR_STEP_MW 11'h032
`define SAGC_FLR_BASE_DB 7'h39
`endif

// ---- rtl/sagc_pkg.sv ----
package sagc_pkg;
    // rates are in units of 0.1 ms per 6 dB
    typedef logic [19:0] sagc_rate_t;
    typedef logic [10:0] sagc_mw_t;
    typedef logic signed [6:0] sagc_db_t;
    typedef logic [2:0] sagc_code3_t;
    typedef enum logic [2:0] {
        SAGC_IDLE,
        SAGC_DEVADDR,
        SAGC_REGADDR,
        SAGC_WR_HI,
        SAGC_WR_LO,
        SAGC_RD_HI,
        SAGC_RD_LO
    } sagc_state_t;
endpackage : sagc_pkg

// ---- rtl/sagc_lut_if.sv ----
`timescale 1ns/1ps
interface sagc_lut_if;
    import sagc_pkg::*;
    sagc_code3_t clip_atk_code;
    sagc_code3_t clip_dcy_code;
    sagc_code3_t pwr_atk_code;
    sagc_code3_t pwr_dcy_code;
    logic [3:0] pwr_thr_code;
    logic [5:0] floor_code;
    sagc_rate_t clip_atk_rate;
    sagc_rate_t clip_dcy_rate;
    sagc_rate_t pwr_atk_rate;
    sagc_rate_t pwr_dcy_rate;
    sagc_mw_t pwr_thr_mw;
    sagc_db_t floor_db;
    modport lut (
        input clip_atk_code, clip_dcy_code, pwr_atk_code, pwr_dcy_code, pwr_thr_code, floor_code,
        output clip_atk_rate, clip_dcy_rate, pwr_atk_rate, pwr_dcy_rate, pwr_thr_mw, floor_db
    );
    modport user (
        output clip_atk_code, clip_dcy_code, pwr_atk_code, pwr_dcy_code, pwr_thr_code, floor_code,
        input clip_atk_rate, clip_dcy_rate, pwr_atk_rate, pwr_dcy_rate, pwr_thr_mw, floor_db
    );
endinterface : sagc_lut_if

// ---- rtl/sagc_rate_lut.sv ----
`timescale 1ns/1ps
`include "sagc_regs.svh"
module sagc_rate_lut (
    sagc_lut_if.lut lut
);
    import sagc_pkg::*;

    // table decode, registered by caller
    always_comb begin
        // RL10: anti-clip attack table
        case (lut.clip_atk_code)
            3'h0: lut.clip_atk_rate = 20'h6;
            3'h1: lut.clip_atk_rate = 20'h36;
            3'h2: lut.clip_atk_rate = 20'h66;
            3'h3: lut.clip_atk_rate = 20'h96;
            3'h4: lut.clip_atk_rate = 20'hc6;
            3'h5: lut.clip_atk_rate = 20'hf6;
            3'h6: lut.clip_atk_rate = 20'h126;
            default: lut.clip_atk_rate = 20'h155;
        endcase
        // RL1: anti-clip decay table
        case (lut.clip_dcy_code)
            3'h0: lut.clip_dcy_rate = 20'h4b0;
            3'h1: lut.clip_dcy_rate = 20'h12c0;
            3'h2: lut.clip_dcy_rate = 20'h2008;
            3'h3: lut.clip_dcy_rate = 20'h2db4;
            3'h4: lut.clip_dcy_rate = 20'h4010;
            3'h5: lut.clip_dcy_rate = 20'h5014;
            3'h6: lut.clip_dcy_rate = 20'h6aa4;
            default: lut.clip_dcy_rate = 20'ha028;
        endcase
        // RL5: power-limit attack table
        case (lut.pwr_atk_code)
            3'h0: lut.pwr_atk_rate = 20'h4b0;
            3'h1: lut.pwr_atk_rate = 20'h12c0;
            3'h2: lut.pwr_atk_rate = 20'h20d0;
            3'h3: lut.pwr_atk_rate = 20'h2ee0;
            3'h4: lut.pwr_atk_rate = 20'h41a0;
            3'h5: lut.pwr_atk_rate = 20'h4fb0;
            3'h6: lut.pwr_atk_rate = 20'h6bd0;
            default: lut.pwr_atk_rate = 20'h9f60;
        endcase
        // RL6: power-limit decay table
        case (lut.pwr_dcy_code)
            3'h0: lut.pwr_dcy_rate = 20'h2a30;
            3'h1: lut.pwr_dcy_rate = 20'h2ee0;
            3'h2: lut.pwr_dcy_rate = 20'h3390;
            3'h3: lut.pwr_dcy_rate = 20'h41a0;
            3'h4: lut.pwr_dcy_rate = 20'h4fb0;
            3'h5: lut.pwr_dcy_rate = 20'h6bd0;
            3'h6: lut.pwr_dcy_rate = 20'h9f60;
            default: lut.pwr_dcy_rate = 20'h13ec0;
        endcase
    end

    // RL11: linear threshold mapping
    assign lut.pwr_thr_mw = `SAGC_THR_BASE_MW + 11'(lut.pwr_thr_code) * `SAGC_THR_STEP_MW;
    // RL8: floor code to dB
    assign lut.floor_db = $signed({1'b0, lut.floor_code}) - $signed(`SAGC_FLR_BASE_DB);
endmodule : sagc_rate_lut

// ---- rtl/speaker_agc_control_regs.sv ----
// Operation
// RL1: anti-clip decay rate from 3-bit field
// RL2: power-limit enable, bit 15, default on
// RL3: bit 12 selects peak or RMS
// RL4: power threshold field bits 11:8
// RL5: power-limit attack rate bits 6:4
// RL6: power-limit decay rate bits 2:0
// RL7: ramp bit: one step per zero-cross
// RL8: gain never below floor field
// RL9: anti-clip enable, bit 15, default on
// RL10: anti-clip attack rate, reset code 100
// RL11: threshold linear, 300mW plus 50mW/step
// RL12: readback last write, unused bits zero
`timescale 1ns/1ps
`include "sagc_regs.svh"
module speaker_agc_control_regs #(
    // bus address, value is arbitrary
    parameter logic [6:0] DEV_ADDR = 7'h3a
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic ANTICLIP_ENABLE,
    output logic [3:0] ANTICLIP_THRESHOLD,
    output sagc_pkg::sagc_rate_t ANTICLIP_ATTACK_RATE,
    output sagc_pkg::sagc_rate_t ANTICLIP_DECAY_RATE,
    output logic POWER_LIMIT_ENABLE,
    output logic POWER_MEASURE_SELECT,
    output sagc_pkg::sagc_mw_t POWER_LIMIT_THRESHOLD,
    output sagc_pkg::sagc_rate_t POWER_LIMIT_ATTACK_RATE,
    output sagc_pkg::sagc_rate_t POWER_LIMIT_DECAY_RATE,
    output logic ZERO_CROSS_STEP_SELECT,
    output sagc_pkg::sagc_db_t GAIN_FLOOR
);
    import sagc_pkg::*;

    // register readback, unmapped indices read zero
    function automatic logic [15:0] reg_read(input logic [7:0] idx, input logic [15:0] r0,
                                             input logic [15:0] r1, input logic [15:0] r2);
        if (idx == `SAGC_OFS_ANTICLIP) begin
            reg_read = r0;
        end else if (idx == `SAGC_OFS_PWRLIM) begin
            reg_read = r1;
        end else if (idx == `SAGC_OFS_RAMPFLR) begin
            reg_read = r2;
        end else begin
            reg_read = 16'h0000;
        end
    endfunction : reg_read

    // pin synchronisers, three stages each
    logic [2:0] scl_sync_reg, scl_sync_next;
    logic [2:0] sda_sync_reg, sda_sync_next;
    logic scl_lvl_reg, scl_lvl_next;
    logic sda_lvl_reg, sda_lvl_next;

    always_comb begin
        scl_sync_next = {scl_sync_reg[1:0], SCL_IN};
        sda_sync_next = {sda_sync_reg[1:0], SDA_IN};
        // a change counts once stages two and three agree
        scl_lvl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_lvl_reg;
        sda_lvl_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_lvl_reg;
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_lvl_reg <= 1'b1;
            sda_lvl_reg <= 1'b1;
        end else if (CE) begin
            scl_sync_reg <= scl_sync_next;
            sda_sync_reg <= sda_sync_next;
            scl_lvl_reg <= scl_lvl_next;
            sda_lvl_reg <= sda_lvl_next;
        end
    end

    // bus events from filtered levels
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_lvl_next & ~scl_lvl_reg;
    assign scl_fall = ~scl_lvl_next & scl_lvl_reg;
    assign bus_start = scl_lvl_reg & scl_lvl_next & sda_lvl_reg & ~sda_lvl_next;
    assign bus_stop = scl_lvl_reg & scl_lvl_next & ~sda_lvl_reg & sda_lvl_next;

    // protocol engine and register bank
    sagc_state_t st_reg, st_next;
    logic [3:0] bitcnt_reg, bitcnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] idx_reg, idx_next;
    logic [7:0] hi_reg, hi_next;
    logic sack_reg, sack_next;
    logic mack_reg, mack_next;
    logic oe_reg, oe_next;
    logic [15:0] anticlip_reg, anticlip_next;
    logic [15:0] pwrlim_reg, pwrlim_next;
    logic [15:0] rampflr_reg, rampflr_next;
    logic [15:0] rd_word;

    assign rd_word = reg_read(idx_reg, anticlip_reg, pwrlim_reg, rampflr_reg);

    always_comb begin
        st_next = st_reg;
        bitcnt_next = bitcnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        idx_next = idx_reg;
        hi_next = hi_reg;
        sack_next = sack_reg;
        mack_next = mack_reg;
        oe_next = oe_reg;
        anticlip_next = anticlip_reg;
        pwrlim_next = pwrlim_reg;
        rampflr_next = rampflr_reg;
        if (bus_stop) begin
            st_next = SAGC_IDLE;
            oe_next = 1'b0;
            sack_next = 1'b0;
            mack_next = 1'b0;
        end else if (bus_start) begin
            // repeated start keeps the register index
            st_next = SAGC_DEVADDR;
            bitcnt_next = 4'h0;
            oe_next = 1'b0;
            sack_next = 1'b0;
            mack_next = 1'b0;
        end else if (st_reg != SAGC_IDLE) begin
            if (scl_rise) begin
                if (mack_reg) begin
                    // master nack ends the read
                    if (sda_lvl_next) begin
                        st_next = SAGC_IDLE;
                    end
                end else if (!sack_reg) begin
                    shift_next = {shift_reg[6:0], sda_lvl_next};
                    bitcnt_next = bitcnt_reg + 4'h1;
                end
            end else if (scl_fall) begin
                if (sack_reg || mack_reg) begin
                    sack_next = 1'b0;
                    mack_next = 1'b0;
                    bitcnt_next = 4'h0;
                    oe_next = 1'b0;
                    if (st_reg == SAGC_RD_HI || st_reg == SAGC_RD_LO) begin
                        if (mack_reg) begin
                            st_next = (st_reg == SAGC_RD_HI) ? SAGC_RD_LO : SAGC_RD_HI;
                            tx_next = (st_reg == SAGC_RD_HI) ? rd_word[7:0] : rd_word[15:8];
                            oe_next = (st_reg == SAGC_RD_HI) ? ~rd_word[7] : ~rd_word[15];
                        end else begin
                            oe_next = ~tx_reg[7];
                        end
                    end
                end else if (st_reg == SAGC_RD_HI || st_reg == SAGC_RD_LO) begin
                    if (bitcnt_reg == 4'h8) begin
                        oe_next = 1'b0;
                        mack_next = 1'b1;
                    end else begin
                        tx_next = {tx_reg[6:0], 1'b0};
                        oe_next = ~tx_reg[6];
                    end
                end else if (bitcnt_reg == 4'h8) begin
                    sack_next = 1'b1;
                    oe_next = 1'b1;
                    case (st_reg)
                        SAGC_DEVADDR: begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                st_next = shift_reg[0] ? SAGC_RD_HI : SAGC_REGADDR;
                                tx_next = rd_word[15:8];
                            end else begin
                                st_next = SAGC_IDLE;
                                sack_next = 1'b0;
                                oe_next = 1'b0;
                            end
                        end
                        SAGC_REGADDR: begin
                            idx_next = shift_reg;
                            st_next = SAGC_WR_HI;
                        end
                        SAGC_WR_HI: begin
                            hi_next = shift_reg;
                            st_next = SAGC_WR_LO;
                        end
                        SAGC_WR_LO: begin
                            st_next = SAGC_WR_HI;
                            // RL12: masked store, unused bits zero
                            if (idx_reg == `SAGC_OFS_ANTICLIP) begin
                                anticlip_next = {hi_reg, shift_reg} & `SAGC_MASK_ANTICLIP;
                            end else if (idx_reg == `SAGC_OFS_PWRLIM) begin
                                pwrlim_next = {hi_reg, shift_reg} & `SAGC_MASK_PWRLIM;
                            end else if (idx_reg == `SAGC_OFS_RAMPFLR) begin
                                rampflr_next = {hi_reg, shift_reg} & `SAGC_MASK_RAMPFLR;
                            end
                        end
                        default: begin
                            st_next = SAGC_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            st_reg <= SAGC_IDLE;
            bitcnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            idx_reg <= 8'h00;
            hi_reg <= 8'h00;
            sack_reg <= 1'b0;
            mack_reg <= 1'b0;
            oe_reg <= 1'b0;
            // RL9: anti-clip on, RL10: attack code 100
            anticlip_reg <= `SAGC_RST_ANTICLIP;
            // RL2: power limit on after reset
            pwrlim_reg <= `SAGC_RST_PWRLIM;
            rampflr_reg <= `SAGC_RST_RAMPFLR;
        end else if (CE) begin
            st_reg <= st_next;
            bitcnt_reg <= bitcnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            idx_reg <= idx_next;
            hi_reg <= hi_next;
            sack_reg <= sack_next;
            mack_reg <= mack_next;
            oe_reg <= oe_next;
            anticlip_reg <= anticlip_next;
            pwrlim_reg <= pwrlim_next;
            rampflr_reg <= rampflr_next;
        end
    end

    // open drain: only ever drives low
    assign SDA_OUT = 1'b0;
    assign SDA_OE = oe_reg;

    // field codes to the tables
    sagc_lut_if lut_bus ();
    assign lut_bus.clip_atk_code = anticlip_reg[`SAGC_ATK_MSB:`SAGC_ATK_LSB];
    assign lut_bus.clip_dcy_code = anticlip_reg[`SAGC_DCY_MSB:`SAGC_DCY_LSB];
    assign lut_bus.pwr_atk_code = pwrlim_reg[`SAGC_ATK_MSB:`SAGC_ATK_LSB];
    assign lut_bus.pwr_dcy_code = pwrlim_reg[`SAGC_DCY_MSB:`SAGC_DCY_LSB];
    assign lut_bus.pwr_thr_code = pwrlim_reg[`SAGC_THR_MSB:`SAGC_THR_LSB];
    assign lut_bus.floor_code = rampflr_reg[`SAGC_FLR_MSB:`SAGC_FLR_LSB];

    sagc_rate_lut u_lut (
        .lut(lut_bus.lut)
    );

    // decoded controls, one cycle behind
    logic ac_en_next, pl_en_next, meas_next, ramp_next;
    logic [3:0] ac_thr_next;
    always_comb begin
        // RL9: anti-clip enable
        ac_en_next = anticlip_reg[`SAGC_BIT_ENABLE];
        ac_thr_next = anticlip_reg[`SAGC_THR_MSB:`SAGC_THR_LSB];
        // RL2: power limit enable
        pl_en_next = pwrlim_reg[`SAGC_BIT_ENABLE];
        // RL3: peak or rms measure
        meas_next = pwrlim_reg[`SAGC_BIT_MEASURE];
        // RL7: single step per zero-cross
        ramp_next = rampflr_reg[`SAGC_BIT_RAMP];
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ANTICLIP_ENABLE <= 1'b1;
            ANTICLIP_THRESHOLD <= 4'h6;
            ANTICLIP_ATTACK_RATE <= 20'hc6;
            ANTICLIP_DECAY_RATE <= 20'h4b0;
            POWER_LIMIT_ENABLE <= 1'b1;
            POWER_MEASURE_SELECT <= 1'b0;
            POWER_LIMIT_THRESHOLD <= `SAGC_THR_BASE_MW;
            POWER_LIMIT_ATTACK_RATE <= 20'h4b0;
            POWER_LIMIT_DECAY_RATE <= 20'h2a30;
            ZERO_CROSS_STEP_SELECT <= 1'b0;
            GAIN_FLOOR <= -$signed(`SAGC_FLR_BASE_DB);
        end else if (CE) begin
            ANTICLIP_ENABLE <= ac_en_next;
            ANTICLIP_THRESHOLD <= ac_thr_next;
            // RL10: attack rate decode
            ANTICLIP_ATTACK_RATE <= lut_bus.clip_atk_rate;
            // RL1: decay rate decode
            ANTICLIP_DECAY_RATE <= lut_bus.clip_dcy_rate;
            POWER_LIMIT_ENABLE <= pl_en_next;
            POWER_MEASURE_SELECT <= meas_next;
            // RL4: threshold in mW
            POWER_LIMIT_THRESHOLD <= lut_bus.pwr_thr_mw;
            // RL5: attack rate decode
            POWER_LIMIT_ATTACK_RATE <= lut_bus.pwr_atk_rate;
            // RL6: decay rate decode
            POWER_LIMIT_DECAY_RATE <= lut_bus.pwr_dcy_rate;
            ZERO_CROSS_STEP_SELECT <= ramp_next;
            // RL8: floor the engine clamps to
            GAIN_FLOOR <= lut_bus.floor_db;
        end
    end
endmodule : speaker_agc_control_regs

// ---- test/sagc_ctl_sva.sv ----
`timescale 1ns/1ps
module sagc_ctl_sva (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SCL_IN,
    input wire logic SDA_OE,
    input wire logic ANTICLIP_ENABLE,
    input wire sagc_pkg::sagc_rate_t ANTICLIP_ATTACK_RATE,
    input wire sagc_pkg::sagc_rate_t ANTICLIP_DECAY_RATE,
    input wire logic POWER_LIMIT_ENABLE,
    input wire logic POWER_MEASURE_SELECT,
    input wire sagc_pkg::sagc_mw_t POWER_LIMIT_THRESHOLD,
    input wire sagc_pkg::sagc_rate_t POWER_LIMIT_ATTACK_RATE,
    input wire sagc_pkg::sagc_rate_t POWER_LIMIT_DECAY_RATE,
    input wire logic ZERO_CROSS_STEP_SELECT,
    input wire sagc_pkg::sagc_db_t GAIN_FLOOR
);
    import sagc_pkg::*;
    // single clock domain
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    property p_clip_rst;
        $rose(RESET_N) |-> ANTICLIP_ENABLE && ANTICLIP_ATTACK_RATE == 20'hc6 && ANTICLIP_DECAY_RATE == 20'h4b0;
    endproperty
    a_clip_rst: assert property (p_clip_rst) else $error("anticlip reset values");
    property p_pwr_rst;
        $rose(RESET_N) |-> POWER_LIMIT_ENABLE && !POWER_MEASURE_SELECT;
    endproperty
    a_pwr_rst: assert property (p_pwr_rst) else $error("power mode reset values");
    property p_thr_rst;
        $rose(RESET_N) |-> POWER_LIMIT_THRESHOLD == 11'h12c;
    endproperty
    a_thr_rst: assert property (p_thr_rst) else $error("threshold reset value");
    property p_rate_rst;
        $rose(RESET_N) |-> POWER_LIMIT_ATTACK_RATE == 20'h4b0 && POWER_LIMIT_DECAY_RATE == 20'h2a30;
    endproperty
    a_rate_rst: assert property (p_rate_rst) else $error("power rate reset values");
    property p_floor_rst;
        $rose(RESET_N) |-> !ZERO_CROSS_STEP_SELECT && GAIN_FLOOR == 7'sh47;
    endproperty
    a_floor_rst: assert property (p_floor_rst) else $error("ramp floor reset values");
    property p_thr_lin;
        POWER_LIMIT_THRESHOLD >= 11'h12c |-> POWER_LIMIT_THRESHOLD <= 11'h41a
            && (POWER_LIMIT_THRESHOLD - 11'h12c) % 11'h032 == 11'h000;
    endproperty
    a_thr_lin: assert property (p_thr_lin) else $error("threshold off grid");
    property p_floor_rng;
        GAIN_FLOOR >= 7'sh47 && GAIN_FLOOR <= 7'sh06;
    endproperty
    a_floor_rng: assert property (p_floor_rng) else $error("floor out of range");
    property p_dcy_set;
        ANTICLIP_DECAY_RATE inside {20'h4b0, 20'h12c0, 20'h2008, 20'h2db4,
            20'h4010, 20'h5014, 20'h6aa4, 20'ha028};
    endproperty
    a_dcy_set: assert property (p_dcy_set) else $error("bad anticlip decay");
    property p_pld_set;
        POWER_LIMIT_DECAY_RATE inside {20'h2a30, 20'h2ee0, 20'h3390,
            20'h41a0, 20'h4fb0, 20'h6bd0, 20'h9f60, 20'h13ec0};
    endproperty
    a_pld_set: assert property (p_pld_set) else $error("bad power decay");
    // words land only while the bus clock is low
    property p_idle_stable;
        SCL_IN [*8] |=> $stable(POWER_LIMIT_THRESHOLD) && $stable(GAIN_FLOOR) && $stable(ANTICLIP_ENABLE);
    endproperty
    a_idle_stable: assert property (p_idle_stable) else $error("setting moved on idle bus");
    property p_ack_low;
        $rose(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 2);
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack while clock high");
endmodule : sagc_ctl_sva

bind speaker_agc_control_regs sagc_ctl_sva u_sva (.CLK(CLK), .RESET_N(RESET_N), .SCL_IN(SCL_IN),
    .SDA_OE(SDA_OE), .ANTICLIP_ENABLE(ANTICLIP_ENABLE), .ANTICLIP_ATTACK_RATE(ANTICLIP_ATTACK_RATE),
    .ANTICLIP_DECAY_RATE(ANTICLIP_DECAY_RATE), .POWER_LIMIT_ENABLE(POWER_LIMIT_ENABLE),
    .POWER_MEASURE_SELECT(POWER_MEASURE_SELECT), .POWER_LIMIT_THRESHOLD(POWER_LIMIT_THRESHOLD),
    .POWER_LIMIT_ATTACK_RATE(POWER_LIMIT_ATTACK_RATE), .POWER_LIMIT_DECAY_RATE(POWER_LIMIT_DECAY_RATE),
    .ZERO_CROSS_STEP_SELECT(ZERO_CROSS_STEP_SELECT), .GAIN_FLOOR(GAIN_FLOOR));

// ---- test/sagc_host_model.sv ----
`timescale 1ns/1ps
module sagc_host_model (
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output wire logic sda
);
    logic sda_drv;
    // released line reads high
    assign sda = sda_drv & ~sda_oe;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // nine clocks per bus phase
    task automatic half();
        repeat (9) @(posedge clk);
    endtask : half
    task automatic start();
        half();
        sda_drv <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        half();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b1;
    endtask : stop
    // set mid-low, sampled at end of high
    task automatic bit_x(input logic v, output logic seen);
        half();
        sda_drv <= v;
        half();
        scl <= 1'b1;
        half();
        seen = sda;
        scl <= 1'b0;
    endtask : bit_x
    task automatic byte_x(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(ack_in, ack_out);
    endtask : byte_x
    task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [15:0] d,
                             output logic [3:0] nak);
        logic [7:0] rx;
        start();
        byte_x({a, 1'b0}, 1'b1, rx, nak[3]);
        byte_x(idx, 1'b1, rx, nak[2]);
        byte_x(d[15:8], 1'b1, rx, nak[1]);
        byte_x(d[7:0], 1'b1, rx, nak[0]);
        stop();
    endtask : write_reg
    // host acks high byte, refuses low
    task automatic read_reg(input logic [6:0] a, input logic [7:0] idx, output logic [15:0] d,
                            output logic [2:0] nak);
        logic [7:0] rx;
        logic dummy;
        start();
        byte_x({a, 1'b0}, 1'b1, rx, nak[2]);
        byte_x(idx, 1'b1, rx, nak[1]);
        start();
        byte_x({a, 1'b1}, 1'b1, rx, nak[0]);
        byte_x(8'hff, 1'b0, d[15:8], dummy);
        byte_x(8'hff, 1'b1, d[7:0], dummy);
        stop();
    endtask : read_reg
endmodule : sagc_host_model

// ---- test/speaker_agc_control_regs_tb.sv ----
`timescale 1ns/1ps
module speaker_agc_control_regs_tb;
    import sagc_pkg::*;
    // bus address, value is arbitrary
    localparam logic [6:0] ADDR = 7'h2d;
    logic clk, reset_n, ce, scl, sda_oe, sda_out, ac_en, pl_en, pl_meas, zc_sel;
    wire logic sda;
    logic [3:0] ac_thr;
    sagc_rate_t ac_atk, ac_dcy, pl_atk, pl_dcy;
    sagc_mw_t pl_thr;
    sagc_db_t gain_flr;
    int failures, checked, cycles;
    sagc_rate_t ac_atk_tab [8] = '{20'h6, 20'h36, 20'h66, 20'h96, 20'hc6, 20'hf6, 20'h126, 20'h155};
    sagc_rate_t ac_dcy_tab [8] = '{20'h4b0, 20'h12c0, 20'h2008, 20'h2db4, 20'h4010, 20'h5014, 20'h6aa4, 20'ha028};
    sagc_rate_t pl_atk_tab [8] = '{20'h4b0, 20'h12c0, 20'h20d0, 20'h2ee0, 20'h41a0, 20'h4fb0, 20'h6bd0, 20'h9f60};
    sagc_rate_t pl_dcy_tab [8] = '{20'h2a30, 20'h2ee0, 20'h3390, 20'h41a0, 20'h4fb0, 20'h6bd0, 20'h9f60, 20'h13ec0};

    speaker_agc_control_regs #(.DEV_ADDR(ADDR)) dut (.CLK(clk), .RESET_N(reset_n), .CE(ce), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ANTICLIP_ENABLE(ac_en), .ANTICLIP_THRESHOLD(ac_thr),
        .ANTICLIP_ATTACK_RATE(ac_atk), .ANTICLIP_DECAY_RATE(ac_dcy), .POWER_LIMIT_ENABLE(pl_en),
        .POWER_MEASURE_SELECT(pl_meas), .POWER_LIMIT_THRESHOLD(pl_thr), .POWER_LIMIT_ATTACK_RATE(pl_atk),
        .POWER_LIMIT_DECAY_RATE(pl_dcy), .ZERO_CROSS_STEP_SELECT(zc_sel), .GAIN_FLOOR(gain_flr));
    sagc_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    // 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_reg(input logic [7:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        logic [2:0] nak;
        host.read_reg(ADDR, idx, d, nak);
        chk("read ack", 20'h0, {17'h0, nak});
        chk("read word", {4'h0, exp}, {4'h0, d});
    endtask : chk_reg
    task automatic chk_outs(input logic en, input logic [3:0] thr, input sagc_rate_t atk, input sagc_rate_t dcy,
        input logic pen, input logic meas, input sagc_mw_t pthr, input sagc_rate_t patk, input sagc_rate_t pdcy,
        input logic zc, input logic [6:0] flr);
        chk("clip enable", {19'h0, en}, {19'h0, ac_en});
        chk("clip threshold", {16'h0, thr}, {16'h0, ac_thr});
        chk("clip attack", atk, ac_atk);
        chk("clip decay", dcy, ac_dcy);
        chk("power enable", {19'h0, pen}, {19'h0, pl_en});
        chk("power measure", {19'h0, meas}, {19'h0, pl_meas});
        chk("power threshold", {9'h0, pthr}, {9'h0, pl_thr});
        chk("power attack", patk, pl_atk);
        chk("power decay", pdcy, pl_dcy);
        chk("ramp select", {19'h0, zc}, {19'h0, zc_sel});
        chk("gain floor", {13'h0, flr}, {13'h0, gain_flr});
        chk("data out", 20'h0, {19'h0, sda_out});
    endtask : chk_outs
    task automatic t_reset_values();
        chk_outs(1'b1, 4'h6, 20'hc6, 20'h4b0, 1'b1, 1'b0, 11'h12c, 20'h4b0, 20'h2a30, 1'b0, 7'h47);
        chk_reg(8'h62, 16'h8640);
        chk_reg(8'h63, 16'h8000);
        chk_reg(8'h64, 16'h0000);
    endtask : t_reset_values
    // each 3-bit code once, unused bits set
    task automatic t_field_codes();
        logic [2:0] k;
        logic [3:0] thr;
        logic [15:0] w62, w63, w64;
        logic [3:0] nak;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            thr = {k, k[0]};
            w62 = {k[0], 3'b111, thr, 1'b1, k, 1'b1, k};
            w63 = {k[1], 2'b11, k[0], thr, 1'b1, k, 1'b1, ~k};
            w64 = {7'h7f, k[0], 2'b11, k, k};
            host.write_reg(ADDR, 8'h62, w62, nak);
            host.write_reg(ADDR, 8'h63, w63, nak);
            host.write_reg(ADDR, 8'h64, w64, nak);
            chk_outs(k[0], thr, ac_atk_tab[k], ac_dcy_tab[k], k[1], k[0], 11'h12c + 11'h032 * {7'h0, thr},
                pl_atk_tab[k], pl_dcy_tab[~k], k[0], {1'b0, k, k} - 7'h39);
            chk_reg(8'h62, w62 & 16'h8f77);
            chk_reg(8'h63, w63 & 16'h9f77);
            chk_reg(8'h64, w64 & 16'h013f);
        end
    endtask : t_field_codes
    // foreign address, unmapped index
    task automatic t_refusals();
        logic [3:0] nak;
        host.write_reg(ADDR, 8'h63, 16'h9234, nak);
        chk("write ack", 20'h0, {16'h0, nak});
        chk("power measure", 20'h1, {19'h0, pl_meas});
        chk("power threshold", 20'h190, {9'h0, pl_thr});
        host.write_reg(ADDR ^ 7'h01, 8'h63, 16'h0000, nak);
        chk("foreign ack", 20'hf, {16'h0, nak});
        host.write_reg(ADDR, 8'h65, 16'hffff, nak);
        chk("unmapped ack", 20'h0, {16'h0, nak});
        chk_reg(8'h65, 16'h0000);
        chk_reg(8'h63, 16'h9234);
    endtask : t_refusals
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        failures = 0;
        checked = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset_values();
        t_field_codes();
        t_refusals();
        tally_and_finish();
    end
endmodule : speaker_agc_control_regs_tb
